// ==== cdbu_map.vh ====
// Register indexes, field positions and reset values of the debug breakpoint unit.
`ifndef CDBU_MAP_VH
`define CDBU_MAP_VH
`define CDBU_IDX_SAVED_STATUS   8'h10
`define CDBU_IDX_SAVED_PC       8'h11
`define CDBU_IDX_SAVED_SP       8'h12
`define CDBU_IDX_FETCH_THREAD   8'h13
`define CDBU_IDX_FETCH_REG      8'h14
`define CDBU_IDX_CAUSE          8'h15
`define CDBU_IDX_INFO           8'h16
`define CDBU_IDX_STOP_MASK      8'h18
`define CDBU_IDX_SCRATCH        8'h20
`define CDBU_IDX_IB_ADDR        8'h30
`define CDBU_IDX_IB_CTRL        8'h40
`define CDBU_IDX_DW_ADDR1       8'h50
`define CDBU_IDX_DW_ADDR2       8'h60
`define CDBU_IDX_DW_CTRL        8'h70
`define CDBU_IDX_RW_MASK        8'h80
`define CDBU_IDX_RW_VALUE       8'h90
`define CDBU_IDX_RW_CTRL        8'h9c
`define CDBU_BIT_ENABLE         0
`define CDBU_BIT_MODE           1
`define CDBU_BIT_LOADS          2
`define CDBU_POS_THREAD_MASK    16
`define CDBU_POS_CAUSE_INDEX    16
`define CDBU_POS_CAUSE_THREAD   8
`define CDBU_WMASK_FETCH_THREAD 32'h0000_00ff
`define CDBU_WMASK_FETCH_REG    32'h0000_001f
`define CDBU_WMASK_CAUSE        32'h0003_ff07
`define CDBU_WMASK_STOP_MASK    32'h0000_00ff
`define CDBU_WMASK_STATUS       32'h0000_06df
`define CDBU_WMASK_CTRL         32'h00ff_0003
`define CDBU_WMASK_DW_CTRL      32'h00ff_0007
`define CDBU_RMASK_STATUS       32'h0000_07df
`define CDBU_CAUSE_HOST         3'h1
`define CDBU_CAUSE_DEBUG_CALL_INSTRUCTION        3'h2
`define CDBU_CAUSE_IBREAK       3'h3
`define CDBU_CAUSE_DWATCH       3'h4
`define CDBU_CAUSE_RWATCH       3'h5
`define CDBU_RESET_WORD         32'h0000_0000
`define CDBU_KIND_IBREAK        2'h0
`define CDBU_KIND_DWATCH        2'h1
`define CDBU_KIND_RWATCH        2'h2
`endif

// ==== cdbu_match.v ====
// One breakpoint or watchpoint comparator of the debug breakpoint unit.
`timescale 1ns/1ps
`include "cdbu_map.vh"
module cdbu_match #(
  parameter [1:0] KIND = 2'h0
) (
  input  wire [31:0] ctrl,
  input  wire [31:0] word_a,
  input  wire [31:0] word_b,
  input  wire        valid,
  input  wire        is_load,
  input  wire [2:0]  thread,
  input  wire [31:0] probe,
  output reg         fire
);
  reg cond_a;
  reg cond_b;
  reg cond;
  reg allowed;
  always @* begin
    cond_a  = 1'b0;
    cond_b  = 1'b0;
    cond    = 1'b0;
    allowed = valid & ctrl[`CDBU_BIT_ENABLE]
              & ctrl[`CDBU_POS_THREAD_MASK + thread];
    if (KIND == `CDBU_KIND_IBREAK) begin
      cond_a = (probe == word_a);
      cond   = ctrl[`CDBU_BIT_MODE] ? ~cond_a : cond_a;
    end else if (KIND == `CDBU_KIND_DWATCH) begin
      cond_a = (probe == word_a);
      cond_b = (probe == word_b);
      cond   = ctrl[`CDBU_BIT_MODE] ? (cond_a | cond_b) : (cond_a & cond_b);
      // Stores always qualify; loads only when the load bit is set.
      if (is_load && !ctrl[`CDBU_BIT_LOADS]) begin
        cond = 1'b0;
      end
    end else begin
      cond_a = ((probe & word_a) == word_b);
      cond_b = ~cond_a;
      cond   = ctrl[`CDBU_BIT_MODE] ? cond_b : cond_a;
    end
    fire = allowed & cond;
  end
endmodule

// ==== cdbu_core.v ====
// Debug breakpoint unit: breakpoints, watchpoints, debug state and Wishbone registers.
// Contract
// - Debugger-writable 8-bit fetch thread select.
// - Debugger-writable 5-bit fetch register select.
// - Record 3-bit cause code; resets zero.
// - Record firing index; lowest wins; zero otherwise.
// - Record causing thread; zero for host.
// - Capture access address or resource identifier.
// - Stop mask holds threads after debug exit.
// - Eight scratch words, also seen by config.
// - Four instruction breakpoints on program counter.
// - Mode bit selects equal or unequal match.
// - Per-thread enable mask gates every breakpoint.
// - Bit zero is master enable, reset off.
// - Four data watchpoints with two addresses.
// - Mode bit selects AND or OR.
// - Load bit lets loads trigger watchpoint.
// - Four resource watchpoints, mask and value.
// - Mode bit selects condition A or B.
// - Capture saved status, counter, stack on entry.
`timescale 1ns/1ps
`include "cdbu_map.vh"
module cdbu_core (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        host_req,
  input  wire        debug_call_instruction_valid,
  input  wire [2:0]  debug_call_instruction_thread,
  input  wire        pc_valid,
  input  wire [2:0]  pc_thread,
  input  wire [31:0] pc_value,
  input  wire        mem_valid,
  input  wire        mem_load,
  input  wire [2:0]  mem_thread,
  input  wire [31:0] mem_addr,
  input  wire        res_valid,
  input  wire [2:0]  res_thread,
  input  wire [31:0] res_id,
  input  wire [31:0] saved_status_word,
  input  wire [31:0] saved_program_counter,
  input  wire [31:0] saved_stack_pointer,
  input  wire        debug_exit,
  input  wire [2:0]  cfg_scratch_sel,
  input  wire        cfg_scratch_we,
  input  wire [31:0] cfg_scratch_wdata,
  output reg  [31:0] cfg_scratch_rdata,
  output reg         debug_irq,
  output reg         debug_mode,
  output reg  [7:0]  thread_halt,
  output reg  [7:0]  fetch_thread,
  output reg  [4:0]  fetch_register
);
  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  function [31:0] merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  sel;
    input [31:0] wmask;
    integer b;
    begin
      merge = old_word;
      for (b = 0; b < 32; b = b + 1) begin
        if (sel[b / 8] && wmask[b]) begin
          merge[b] = new_word[b];
        end
      end
    end
  endfunction

  function [1:0] low_idx;
    input [3:0] v;
    begin
      if (v[0]) begin
        low_idx = 2'h0;
      end else if (v[1]) begin
        low_idx = 2'h1;
      end else if (v[2]) begin
        low_idx = 2'h2;
      end else begin
        low_idx = 2'h3;
      end
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  reg [31:0] status_copy_reg;
  reg [31:0] pc_copy_reg;
  reg [31:0] sp_copy_reg;
  reg [31:0] fetch_thread_reg;
  reg [31:0] fetch_reg_reg;
  reg [31:0] cause_reg;
  reg [31:0] info_reg;
  reg [31:0] stop_mask_reg;
  reg [31:0] scratch_reg [0:7];
  reg [31:0] ib_addr_reg [0:3];
  reg [31:0] ib_ctrl_reg [0:3];
  reg [31:0] dw_addr1_reg [0:3];
  reg [31:0] dw_addr2_reg [0:3];
  reg [31:0] dw_ctrl_reg [0:3];
  reg [31:0] rw_mask_reg [0:3];
  reg [31:0] rw_value_reg [0:3];
  reg [31:0] rw_ctrl_reg [0:3];

  wire [7:0] idx = wb_adr_i[9:2];
  wire       req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr  = req & wb_we_i;

  // ---------------------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------------------
  wire [3:0] ib_fire;
  wire [3:0] dw_fire;
  wire [3:0] rw_fire;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : unit
      cdbu_match #(.KIND(`CDBU_KIND_IBREAK)) u_ib (
        .ctrl    (ib_ctrl_reg[g]),
        .word_a  (ib_addr_reg[g]),
        .word_b  (ib_addr_reg[g]),
        .valid   (pc_valid),
        .is_load (1'b0),
        .thread  (pc_thread),
        .probe   (pc_value),
        .fire    (ib_fire[g])
      );
      cdbu_match #(.KIND(`CDBU_KIND_DWATCH)) u_dw (
        .ctrl    (dw_ctrl_reg[g]),
        .word_a  (dw_addr1_reg[g]),
        .word_b  (dw_addr2_reg[g]),
        .valid   (mem_valid),
        .is_load (mem_load),
        .thread  (mem_thread),
        .probe   (mem_addr),
        .fire    (dw_fire[g])
      );
      cdbu_match #(.KIND(`CDBU_KIND_RWATCH)) u_rw (
        .ctrl    (rw_ctrl_reg[g]),
        .word_a  (rw_mask_reg[g]),
        .word_b  (rw_value_reg[g]),
        .valid   (res_valid),
        .is_load (1'b0),
        .thread  (res_thread),
        .probe   (res_id),
        .fire    (rw_fire[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Debug entry selection
  // ---------------------------------------------------------------------------
  // Only one event is taken per entry; the host has highest priority.
  reg        evt;
  reg [2:0]  evt_cause;
  reg [1:0]  evt_index;
  reg [2:0]  evt_thread;
  reg        evt_info_we;
  reg [31:0] evt_info;
  always @* begin
    evt         = ~debug_mode;
    evt_cause   = 3'h0;
    evt_index   = 2'h0;
    evt_thread  = 3'h0;
    evt_info_we = 1'b0;
    evt_info    = 32'h0000_0000;
    if (host_req) begin
      evt_cause = `CDBU_CAUSE_HOST;
    end else if (debug_call_instruction_valid) begin
      evt_cause  = `CDBU_CAUSE_DEBUG_CALL_INSTRUCTION;
      evt_thread = debug_call_instruction_thread;
    end else if (|ib_fire) begin
      evt_cause  = `CDBU_CAUSE_IBREAK;
      evt_index  = low_idx(ib_fire);
      evt_thread = pc_thread;
    end else if (|dw_fire) begin
      evt_cause   = `CDBU_CAUSE_DWATCH;
      evt_index   = low_idx(dw_fire);
      evt_thread  = mem_thread;
      evt_info_we = 1'b1;
      evt_info    = mem_addr;
    end else if (|rw_fire) begin
      evt_cause   = `CDBU_CAUSE_RWATCH;
      evt_index   = low_idx(rw_fire);
      evt_thread  = res_thread;
      evt_info_we = 1'b1;
      evt_info    = res_id;
    end else begin
      evt = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes and debug state
  // ---------------------------------------------------------------------------
  integer i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_copy_reg  <= `CDBU_RESET_WORD;
      pc_copy_reg      <= `CDBU_RESET_WORD;
      sp_copy_reg      <= `CDBU_RESET_WORD;
      fetch_thread_reg <= `CDBU_RESET_WORD;
      fetch_reg_reg    <= `CDBU_RESET_WORD;
      cause_reg        <= `CDBU_RESET_WORD;
      info_reg         <= `CDBU_RESET_WORD;
      stop_mask_reg    <= `CDBU_RESET_WORD;
      debug_mode       <= 1'b0;
      debug_irq        <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        scratch_reg[i] <= `CDBU_RESET_WORD;
      end
      for (i = 0; i < 4; i = i + 1) begin
        ib_addr_reg[i]  <= `CDBU_RESET_WORD;
        ib_ctrl_reg[i]  <= `CDBU_RESET_WORD;
        dw_addr1_reg[i] <= `CDBU_RESET_WORD;
        dw_addr2_reg[i] <= `CDBU_RESET_WORD;
        dw_ctrl_reg[i]  <= `CDBU_RESET_WORD;
        rw_mask_reg[i]  <= `CDBU_RESET_WORD;
        rw_value_reg[i] <= `CDBU_RESET_WORD;
        rw_ctrl_reg[i]  <= `CDBU_RESET_WORD;
      end
    end else begin
      debug_irq <= evt;
      if (cfg_scratch_we) begin
        scratch_reg[cfg_scratch_sel] <= cfg_scratch_wdata;
      end
      if (wr) begin
        if (idx == `CDBU_IDX_SAVED_STATUS) begin
          status_copy_reg <= merge(status_copy_reg, wb_dat_i, wb_sel_i, `CDBU_WMASK_STATUS);
        end else if (idx == `CDBU_IDX_SAVED_PC) begin
          pc_copy_reg <= merge(pc_copy_reg, wb_dat_i, wb_sel_i, 32'hffff_ffff);
        end else if (idx == `CDBU_IDX_SAVED_SP) begin
          sp_copy_reg <= merge(sp_copy_reg, wb_dat_i, wb_sel_i, 32'hffff_ffff);
        end else if (idx == `CDBU_IDX_FETCH_THREAD) begin
          fetch_thread_reg <= merge(fetch_thread_reg, wb_dat_i, wb_sel_i,
                                    `CDBU_WMASK_FETCH_THREAD);
        end else if (idx == `CDBU_IDX_FETCH_REG) begin
          fetch_reg_reg <= merge(fetch_reg_reg, wb_dat_i, wb_sel_i,
                                 `CDBU_WMASK_FETCH_REG);
        end else if (idx == `CDBU_IDX_CAUSE) begin
          cause_reg <= merge(cause_reg, wb_dat_i, wb_sel_i, `CDBU_WMASK_CAUSE);
        end else if (idx == `CDBU_IDX_INFO) begin
          info_reg <= merge(info_reg, wb_dat_i, wb_sel_i, 32'hffff_ffff);
        end else if (idx == `CDBU_IDX_STOP_MASK) begin
          stop_mask_reg <= merge(stop_mask_reg, wb_dat_i, wb_sel_i,
                                 `CDBU_WMASK_STOP_MASK);
        end else if (idx[7:3] == `CDBU_IDX_SCRATCH >> 3) begin
          scratch_reg[idx[2:0]] <= merge(scratch_reg[idx[2:0]], wb_dat_i, wb_sel_i,
                                         32'hffff_ffff);
        end else if (idx[7:2] == `CDBU_IDX_IB_ADDR >> 2) begin
          ib_addr_reg[idx[1:0]] <= merge(ib_addr_reg[idx[1:0]], wb_dat_i, wb_sel_i,
                                         32'hffff_ffff);
        end else if (idx[7:2] == `CDBU_IDX_IB_CTRL >> 2) begin
          ib_ctrl_reg[idx[1:0]] <= merge(ib_ctrl_reg[idx[1:0]], wb_dat_i, wb_sel_i,
                                         `CDBU_WMASK_CTRL);
        end else if (idx[7:2] == `CDBU_IDX_DW_ADDR1 >> 2) begin
          dw_addr1_reg[idx[1:0]] <= merge(dw_addr1_reg[idx[1:0]], wb_dat_i, wb_sel_i,
                                          32'hffff_ffff);
        end else if (idx[7:2] == `CDBU_IDX_DW_ADDR2 >> 2) begin
          dw_addr2_reg[idx[1:0]] <= merge(dw_addr2_reg[idx[1:0]], wb_dat_i, wb_sel_i,
                                          32'hffff_ffff);
        end else if (idx[7:2] == `CDBU_IDX_DW_CTRL >> 2) begin
          dw_ctrl_reg[idx[1:0]] <= merge(dw_ctrl_reg[idx[1:0]], wb_dat_i, wb_sel_i,
                                         `CDBU_WMASK_DW_CTRL);
        end else if (idx[7:2] == `CDBU_IDX_RW_MASK >> 2) begin
          rw_mask_reg[idx[1:0]] <= merge(rw_mask_reg[idx[1:0]], wb_dat_i, wb_sel_i,
                                         32'hffff_ffff);
        end else if (idx[7:2] == `CDBU_IDX_RW_VALUE >> 2) begin
          rw_value_reg[idx[1:0]] <= merge(rw_value_reg[idx[1:0]], wb_dat_i, wb_sel_i,
                                          32'hffff_ffff);
        end else if (idx[7:2] == `CDBU_IDX_RW_CTRL >> 2) begin
          rw_ctrl_reg[idx[1:0]] <= merge(rw_ctrl_reg[idx[1:0]], wb_dat_i, wb_sel_i,
                                         `CDBU_WMASK_CTRL);
        end
      end
      // Hardware capture follows the bus write so an entry is never lost.
      if (evt) begin
        debug_mode <= 1'b1;
        cause_reg  <= {14'h0000, evt_index, 5'h00, evt_thread, 5'h00, evt_cause};
        if (evt_info_we) begin
          info_reg <= evt_info;
        end
        status_copy_reg <= saved_status_word & `CDBU_RMASK_STATUS;
        pc_copy_reg     <= saved_program_counter;
        sp_copy_reg     <= saved_stack_pointer;
      end else if (debug_exit) begin
        debug_mode <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs and bus read
  // ---------------------------------------------------------------------------
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0000_0000;
    if (idx == `CDBU_IDX_SAVED_STATUS) begin
      rd_word = status_copy_reg;
    end else if (idx == `CDBU_IDX_SAVED_PC) begin
      rd_word = pc_copy_reg;
    end else if (idx == `CDBU_IDX_SAVED_SP) begin
      rd_word = sp_copy_reg;
    end else if (idx == `CDBU_IDX_FETCH_THREAD) begin
      rd_word = fetch_thread_reg;
    end else if (idx == `CDBU_IDX_FETCH_REG) begin
      rd_word = fetch_reg_reg;
    end else if (idx == `CDBU_IDX_CAUSE) begin
      rd_word = cause_reg;
    end else if (idx == `CDBU_IDX_INFO) begin
      rd_word = info_reg;
    end else if (idx == `CDBU_IDX_STOP_MASK) begin
      rd_word = stop_mask_reg;
    end else if (idx[7:3] == `CDBU_IDX_SCRATCH >> 3) begin
      rd_word = scratch_reg[idx[2:0]];
    end else if (idx[7:2] == `CDBU_IDX_IB_ADDR >> 2) begin
      rd_word = ib_addr_reg[idx[1:0]];
    end else if (idx[7:2] == `CDBU_IDX_IB_CTRL >> 2) begin
      rd_word = ib_ctrl_reg[idx[1:0]];
    end else if (idx[7:2] == `CDBU_IDX_DW_ADDR1 >> 2) begin
      rd_word = dw_addr1_reg[idx[1:0]];
    end else if (idx[7:2] == `CDBU_IDX_DW_ADDR2 >> 2) begin
      rd_word = dw_addr2_reg[idx[1:0]];
    end else if (idx[7:2] == `CDBU_IDX_DW_CTRL >> 2) begin
      rd_word = dw_ctrl_reg[idx[1:0]];
    end else if (idx[7:2] == `CDBU_IDX_RW_MASK >> 2) begin
      rd_word = rw_mask_reg[idx[1:0]];
    end else if (idx[7:2] == `CDBU_IDX_RW_VALUE >> 2) begin
      rd_word = rw_value_reg[idx[1:0]];
    end else if (idx[7:2] == `CDBU_IDX_RW_CTRL >> 2) begin
      rd_word = rw_ctrl_reg[idx[1:0]];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h0000_0000;
      cfg_scratch_rdata <= 32'h0000_0000;
      thread_halt       <= 8'h00;
      fetch_thread      <= 8'h00;
      fetch_register    <= 5'h00;
    end else begin
      wb_ack_o          <= req;
      wb_dat_o          <= (req && !wb_we_i) ? rd_word : 32'h0000_0000;
      cfg_scratch_rdata <= scratch_reg[cfg_scratch_sel];
      // Masked threads stay halted whenever the processor is out of debug mode.
      thread_halt       <= debug_mode ? 8'h00 : stop_mask_reg[7:0];
      fetch_thread      <= fetch_thread_reg[7:0];
      fetch_register    <= fetch_reg_reg[4:0];
    end
  end
endmodule

// ==== cdbu_core_assertions.sv ====
// Concurrent checks on the ports of the debug breakpoint unit.
`timescale 1ns/1ps
module cdbu_core_assertions (
  input wire        clk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        host_req,
  input wire        debug_call_instruction_valid,
  input wire        debug_exit,
  input wire        debug_irq,
  input wire        debug_mode,
  input wire [7:0]  thread_halt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_entry;
    debug_irq && debug_mode ##1 !debug_irq;
  endsequence
  a_bus_answer: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus request not answered by a single ack");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_host_entry: assert property (!debug_mode && host_req |=> s_entry)
    else $error("host request did not enter debug mode");
  a_debug_call_instruction_entry: assert property (!debug_mode && debug_call_instruction_valid |=> s_entry)
    else $error("debug call did not enter debug mode");
  a_irq_fresh: assert property (debug_irq |-> !$past(debug_mode))
    else $error("debug interrupt without a fresh entry");
  a_no_reentry: assert property (debug_mode |=> !debug_irq)
    else $error("event taken while in debug mode");
  a_exit_leaves: assert property (debug_mode && debug_exit |=> !debug_mode)
    else $error("debug mode kept after exit");
  a_mode_holds: assert property (debug_mode && !debug_exit |=> debug_mode)
    else $error("debug mode dropped without exit");
  a_halt_clear: assert property (debug_mode [*2] |-> thread_halt == 8'h00)
    else $error("threads held while in debug mode");
endmodule
bind cdbu_core cdbu_core_assertions i_cdbu_core_assertions (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_req(host_req),
  .debug_call_instruction_valid(debug_call_instruction_valid), .debug_exit(debug_exit), .debug_irq(debug_irq),
  .debug_mode(debug_mode), .thread_halt(thread_halt));

// ==== cdbu_pipe_model.sv ====
// Behavioural model of the pipeline that feeds events to the debug unit.
`timescale 1ns/1ps
module cdbu_pipe_model (
  input  wire        clk,
  input  wire [7:0]  thread_halt,
  output reg         debug_call_instruction_valid,
  output reg  [2:0]  debug_call_instruction_thread,
  output reg         pc_valid,
  output reg  [2:0]  pc_thread,
  output reg  [31:0] pc_value,
  output reg         mem_valid,
  output reg         mem_load,
  output reg  [2:0]  mem_thread,
  output reg  [31:0] mem_addr,
  output reg         res_valid,
  output reg  [2:0]  res_thread,
  output reg  [31:0] res_id
);
  initial begin
    {debug_call_instruction_valid, pc_valid, mem_valid, res_valid, mem_load} = 5'h00;
    {debug_call_instruction_thread, pc_thread, mem_thread, res_thread} = 12'h000;
    {pc_value, mem_addr, res_id} = 96'h0;
  end
  // Kind 0 fetch, 1 memory, 2 resource, 3 debug call; one cycle per event.
  task issue(input [1:0] k, input [2:0] t, input [31:0] v, input ld);
    begin
      @(posedge clk);
      if (!thread_halt[t]) begin
        debug_call_instruction_valid <= (k == 2'h3);
        pc_valid <= (k == 2'h0);
        mem_valid <= (k == 2'h1);
        res_valid <= (k == 2'h2);
      end
      {debug_call_instruction_thread, pc_thread, mem_thread, res_thread} <= {4{t}};
      {pc_value, mem_addr, res_id} <= {3{v}};
      mem_load <= ld;
      @(posedge clk);
      {debug_call_instruction_valid, pc_valid, mem_valid, res_valid} <= 4'h0;
      {pc_value, mem_addr, res_id} <= {3{~v}};
    end
  endtask
endmodule

// ==== tb.sv ====
// Self-checking testbench of the debug breakpoint unit.
`timescale 1ns/1ps
module tb;
  reg          clk, rst_n, cyc, stb, we, host_req, debug_exit, cfg_we;
  reg  [9:0]   adr;
  reg  [2:0]   cfg_sel;
  reg  [31:0]  dat, sv_st, sv_pc, sv_sp, a, b, c, cfg_wd;
  reg  [31:0]  scr [8];
  wire [31:0]  wb_dat_o, cfg_scratch_rdata, pc_value, mem_addr, res_id;
  wire         wb_ack_o, debug_irq, debug_mode, debug_call_instruction_valid, pc_valid;
  wire         mem_valid, mem_load, res_valid;
  wire [2:0]   debug_call_instruction_thread, pc_thread, mem_thread, res_thread;
  wire [7:0]   thread_halt, fetch_thread;
  wire [4:0]   fetch_register;
  logic [32:0] exp_q[$];
  logic [32:0] e_m;
  logic [7:0]  rst_idx [5] = '{8'h15, 8'h40, 8'h73, 8'h9f, 8'h3f};
  int          fail_count, total_checks, i;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  cdbu_core i_cdbu_core (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .host_req(host_req), .debug_call_instruction_valid(debug_call_instruction_valid),
    .debug_call_instruction_thread(debug_call_instruction_thread), .pc_valid(pc_valid), .pc_thread(pc_thread),
    .pc_value(pc_value), .mem_valid(mem_valid), .mem_load(mem_load),
    .mem_thread(mem_thread), .mem_addr(mem_addr), .res_valid(res_valid),
    .res_thread(res_thread), .res_id(res_id), .saved_status_word(sv_st),
    .saved_program_counter(sv_pc), .saved_stack_pointer(sv_sp), .debug_exit(debug_exit),
    .cfg_scratch_sel(cfg_sel), .cfg_scratch_we(cfg_we), .cfg_scratch_wdata(cfg_wd),
    .cfg_scratch_rdata(cfg_scratch_rdata), .debug_irq(debug_irq), .debug_mode(debug_mode),
    .thread_halt(thread_halt), .fetch_thread(fetch_thread), .fetch_register(fetch_register));
  cdbu_pipe_model i_cdbu_pipe_model (.clk(clk), .thread_halt(thread_halt),
    .debug_call_instruction_valid(debug_call_instruction_valid), .debug_call_instruction_thread(debug_call_instruction_thread), .pc_valid(pc_valid),
    .pc_thread(pc_thread), .pc_value(pc_value), .mem_valid(mem_valid),
    .mem_load(mem_load), .mem_thread(mem_thread), .mem_addr(mem_addr),
    .res_valid(res_valid), .res_thread(res_thread), .res_id(res_id));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    begin
      total_checks++;
      if (s !== e) begin
        fail_count++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Each request queues an entry; the monitor compares read data only.
  task bus(input w, input [7:0] x, input [31:0] d, input [32:0] e);
    int n;
    begin
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, x, 2'b00, d};
      exp_q.push_back(e);
      for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk);
      if (n == 20) begin
        fail_count++;
        summarize;
      end
      {cyc, stb} <= 2'b00;
    end
  endtask
  task wr(input [7:0] x, input [31:0] d);
    bus(1'b1, x, d, 33'h0);
  endtask
  task rd(input [7:0] x, input [31:0] e);
    bus(1'b0, x, $urandom, {1'b1, e});
  endtask
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
      e_m = exp_q.pop_front();
      if (e_m[32]) chk("read data", wb_dat_o, e_m[31:0]);
    end
  end
  task irq(input want);
    int n;
    reg seen;
    begin
      seen = 1'b0;
      for (n = 0; n < 4; n++) begin
        #1;
        if (debug_irq === 1'b1) seen = 1'b1;
        @(posedge clk);
      end
      chk("debug_irq", {31'h0, seen}, {31'h0, want});
    end
  endtask
  task ev(input [1:0] k, input [2:0] t, input [31:0] v, input ld, input want);
    i_cdbu_pipe_model.issue(k, t, v, ld);
    irq(want);
  endtask
  task lv;
    begin
      @(posedge clk);
      debug_exit <= 1'b1;
      @(posedge clk);
      debug_exit <= 1'b0;
    end
  endtask
  initial begin
    {cyc, stb, we, host_req, debug_exit, rst_n, adr, cfg_sel, dat, cfg_we, cfg_wd} = 0;
    {fail_count, total_checks} = 0;
    void'($urandom(32'h045c));
    {sv_st, sv_pc, sv_sp} = {$urandom, $urandom, $urandom};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wr(8'h3f, 32'hffff_ffff);
    foreach (rst_idx[j]) rd(rst_idx[j], 32'h0000_0000);
    wr(8'h41, 32'hffff_ffff);
    wr(8'h72, 32'hffff_ffff);
    wr(8'h13, 32'hffff_ffff);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h13, 32'h0000_00ff);
    rd(8'h14, 32'h0000_001f);
    rd(8'h41, 32'h00ff_0003);
    rd(8'h72, 32'h00ff_0007);
    chk("fetch_thread", {24'h0, fetch_thread}, 32'h0000_00ff);
    chk("fetch_register", {27'h0, fetch_register}, 32'h0000_001f);
    wr(8'h41, 32'h0000_0000);
    wr(8'h72, 32'h0000_0000);
    for (i = 0; i < 8; i++) begin
      scr[i] = $urandom;
      wr(8'h20 + i[7:0], scr[i]);
    end
    for (i = 0; i < 8; i++) begin
      rd(8'h20 + i[7:0], scr[i]);
      cfg_sel <= i[2:0];
      repeat (2) @(posedge clk);
      chk("cfg_scratch_rdata", cfg_scratch_rdata, scr[i]);
    end
    cfg_wd <= $urandom;
    cfg_we <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    rd(8'h27, cfg_wd);
    $display("test registers done");
    @(posedge clk);
    host_req <= 1'b1;
    @(posedge clk);
    host_req <= 1'b0;
    irq(1'b1);
    chk("debug_mode", {31'h0, debug_mode}, 32'h0000_0001);
    rd(8'h15, 32'h0000_0001);
    rd(8'h11, sv_pc);
    rd(8'h12, sv_sp);
    rd(8'h10, sv_st & 32'h0000_07df);
    wr(8'h18, 32'h0000_0024);
    chk("thread_halt", {24'h0, thread_halt}, 32'h0000_0000);
    lv;
    repeat (2) @(posedge clk);
    chk("thread_halt", {24'h0, thread_halt}, 32'h0000_0024);
    chk("debug_mode", {31'h0, debug_mode}, 32'h0000_0000);
    ev(2'h3, 3'h5, 32'h0000_0000, 1'b0, 1'b0);
    ev(2'h3, 3'h4, 32'h0000_0000, 1'b0, 1'b1);
    rd(8'h15, 32'h0000_0402);
    wr(8'h18, 32'h0000_0000);
    lv;
    $display("test entry done");
    a = $urandom | 32'h0000_0001;
    wr(8'h31, a);
    wr(8'h32, a);
    wr(8'h41, 32'h0008_0001);
    wr(8'h42, 32'h0008_0001);
    ev(2'h0, 3'h2, a, 1'b0, 1'b0);
    ev(2'h0, 3'h3, a, 1'b0, 1'b1);
    rd(8'h15, 32'h0001_0303);
    lv;
    wr(8'h41, 32'h0008_0000);
    wr(8'h42, 32'h0000_0000);
    ev(2'h0, 3'h3, a, 1'b0, 1'b0);
    wr(8'h40, 32'h0040_0003);
    ev(2'h0, 3'h6, 32'h0000_0000, 1'b0, 1'b0);
    ev(2'h0, 3'h6, a, 1'b0, 1'b1);
    rd(8'h15, 32'h0000_0603);
    lv;
    wr(8'h40, 32'h0000_0000);
    $display("test instruction breakpoints done");
    b = $urandom;
    c = ~b;
    wr(8'h53, b);
    wr(8'h63, c);
    wr(8'h73, 32'h0004_0003);
    ev(2'h1, 3'h2, c, 1'b1, 1'b0);
    wr(8'h73, 32'h0004_0007);
    ev(2'h1, 3'h2, c, 1'b1, 1'b1);
    rd(8'h15, 32'h0003_0204);
    rd(8'h16, c);
    lv;
    wr(8'h73, 32'h0004_0001);
    ev(2'h1, 3'h2, b, 1'b0, 1'b0);
    wr(8'h63, b);
    ev(2'h1, 3'h2, b, 1'b0, 1'b1);
    lv;
    wr(8'h73, 32'h0000_0000);
    wr(8'h82, 32'h0000_00ff);
    wr(8'h92, 32'h0000_0042);
    wr(8'h9e, 32'h0001_0001);
    ev(2'h2, 3'h0, 32'h0000_1243, 1'b0, 1'b0);
    ev(2'h2, 3'h0, 32'h0000_1242, 1'b0, 1'b1);
    rd(8'h15, 32'h0002_0005);
    rd(8'h16, 32'h0000_1242);
    lv;
    wr(8'h9e, 32'h0001_0003);
    ev(2'h2, 3'h0, 32'h0000_1242, 1'b0, 1'b0);
    ev(2'h2, 3'h0, 32'h0000_1243, 1'b0, 1'b1);
    lv;
    $display("test watchpoints done");
    summarize;
  end
endmodule
